/* core/asp_map.svh */
// Behaviour
// RULE1: in slave framed modes the output word and input word share one frame.
// RULE2: an all-zero input word changes no register.
// RULE3: two-wire mode only after a control write sets the wire-count bit.
// RULE4: in two-wire mode a frame is either a read or a write.
// RULE5: host should start conversions by pin in self-clocking modes.
// RULE6: self-clocking frames move both words and only during a conversion.
// RULE7: with data input low, a start pulse converts and the result shifts out.
// RULE8: host must not ground the data input in two-wire mode.
// RULE9: with shared clocks in two-wire or SPI mode, frame sync low exactly 16 clocks.
// RULE10: edge-framed mode tolerates frame sync low longer than 16 clocks.
// RULE11: self-clocking serial clock must not feed the master clock input.
// RULE12: two-wire host holds frame sync low and uses clock and one data line.
// RULE13: byte host writes control in two bytes, waits, reads two bytes.
// RULE14: SPI host without frame sync is clock master, sync grounded, polarity one.
// RULE15: the device raises a conversion-done indication when a conversion ends.
// RULE16: a full-duplex frame accepts a new start while shifting the old result.
// RULE17: queued SPI host ties select b high and drives frame sync from slave select.
// RULE18: DSP slave uses external clock and sync, 16-bit words, one sync per word.
// RULE19: DSP master in edge mode makes clock and sync, sync at word start.
// RULE20: a serial clock shared with the master clock runs continuously.
// RULE21: edge mode starts on frame sync fall and counts 16 clocks internally.
// RULE22: continuous mode outputs master clock; gated mode only while frame active.
// RULE23: mode comes from the two select straps and the wire-count bit.
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_WORD_BITS 16
`define ASP_BUF_DEPTH 2
`define ASP_RESULT_RST 16'h0000
// idle pin levels: frame sync and start pin high, everything else low
`define ASP_PIN_IDLE 8'h48
`define ASP_SEL_SPI 2'h0
`define ASP_SEL_EDGE 2'h1
`define ASP_SEL_GATED 2'h2
`define ASP_SEL_CONT 2'h3
`endif

/* core/asp_pkg.sv */
package asp_pkg;
    // interface modes
    typedef enum logic [2:0] {
        ASP_MODE_TWO_WIRE,
        ASP_MODE_SPI,
        ASP_MODE_EDGE,
        ASP_MODE_GATED,
        ASP_MODE_CONT
    } asp_mode_type;

    // every pin level that arrives from outside the clock domain
    typedef struct packed {
        logic serialClock;
        logic frameSyncN;
        logic dataIn;
        logic dataIo;
        logic conversionStartN;
        logic masterClockIn;
        logic interfaceSelectA;
        logic interfaceSelectB;
    } asp_pins_type;
endpackage

/* core/asp_buf.sv */
`timescale 1ns/1ps
module asp_buf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // filling side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // draining side
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    logic [WIDTH-1:0] data_q [DEPTH];
    wire  [WIDTH-1:0] dataD  [DEPTH];
    logic [DEPTH-1:0] vld_q;
    wire  [DEPTH-1:0] vldD;
    wire  [DEPTH-1:0] shV;
    wire  [DEPTH:0]   vldX = {1'b0, vld_q};
    wire  [DEPTH:0]   room = {shV, 1'b1};
    wire              pop  = vld_q[0] & outReady;
    wire              push = inValid & ~vld_q[DEPTH-1];

    if (DEPTH < 2) begin : g_bad
        $error("asp_buf needs at least two entries");
    end

    // head is always entry 0, so the outputs come straight from flops
    assign outValid = vld_q[0];
    assign outData  = data_q[0];
    assign inReady  = ~vld_q[DEPTH-1];

    // per entry: shift down on a pop, load the first slot left empty after it
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        wire load = push & ~shV[i] & room[i];
        assign shV[i]  = pop ? vldX[i+1] : vld_q[i];
        assign vldD[i] = shV[i] | load;
        if (i == DEPTH - 1) begin : g_tail
            assign dataD[i] = load ? inData : data_q[i];
        end else begin : g_body
            assign dataD[i] = load ? inData : (pop ? data_q[i+1] : data_q[i]);
        end
    end

    // one process owns all valid bits
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vld_q <= '0;
        end else begin
            vld_q <= vldD;
        end
    end

    // data needs no reset; valid guards it
    always_ff @(posedge sys_clk) begin
        data_q <= dataD;
    end
endmodule

/* core/asp_port.sv */
`timescale 1ns/1ps
`include "asp_map.svh"
module asp_port #(
    parameter int WORD_W    = `ASP_WORD_BITS,
    parameter int BUF_DEPTH = `ASP_BUF_DEPTH
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // device pins, asynchronous to sys_clk
    input  wire asp_pkg::asp_pins_type linePins,
    // pin drivers
    output logic                       dataOut,
    output logic                       dataOutOe,
    output logic                       dataIoOut,
    output logic                       dataIoOe,
    output logic                       serialClockOut,
    output logic                       serialClockOe,
    output logic                       frameSyncOutN,
    output logic                       frameSyncOe,
    output logic                       busy,
    // control and status bits
    input  wire logic                  twoWireEn,
    input  wire logic                  swConvStart,
    output asp_pkg::asp_mode_type      mode,
    // conversion engine
    output logic                       convStart,
    input  wire logic                  convDoneIn,
    input  wire logic [WORD_W-1:0]     convResult,
    output logic                       convDone,
    // received words towards the registers
    output logic                       wrValid,
    output logic [WORD_W-1:0]          wrWord,
    input  wire logic                  wrReady
);
    import asp_pkg::*;

    localparam int             CW       = $clog2(WORD_W + 1);
    localparam logic [CW-1:0]  LAST_BIT = CW'(WORD_W - 1);

    if (WORD_W < 2 || WORD_W > 32) begin : g_bad
        $error("asp_port word width out of range");
    end

    asp_pins_type      syncA_q, syncB_q, prev_q;
    asp_mode_type      mode_q, modeD;
    logic              frameActive_q, readDir_q, pending_q, pend_q, busy_q;
    logic [CW-1:0]     bitCnt_q;
    logic [WORD_W-1:0] tx_q, rx_q, result_q;
    logic              dataBit_q, dataOutOe_q, dataIoOe_q;
    logic              sclkOut_q, sclkOe_q, fsyncN_q, fsyncOe_q;
    logic              convStart_q, convDone_q;
    logic              bufInReady;

    // two flops on every pin before any logic looks at it; reset to idle
    // levels so no false sync fall or start edge follows reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            syncA_q <= `ASP_PIN_IDLE;
            syncB_q <= `ASP_PIN_IDLE;
            prev_q  <= `ASP_PIN_IDLE;
        end else begin
            syncA_q <= linePins;
            syncB_q <= syncA_q;
            prev_q  <= syncB_q;
        end
    end

    // edges seen on the synchronised pins
    wire sclkRise  = syncB_q.serialClock & ~prev_q.serialClock;
    wire sclkFall  = ~syncB_q.serialClock & prev_q.serialClock;
    wire mclkRise  = syncB_q.masterClockIn & ~prev_q.masterClockIn;
    wire mclkFall  = ~syncB_q.masterClockIn & prev_q.masterClockIn;
    wire fsyncFall = ~syncB_q.frameSyncN & prev_q.frameSyncN;
    wire cstFall   = ~syncB_q.conversionStartN & prev_q.conversionStartN;
    wire cstRise   = syncB_q.conversionStartN & ~prev_q.conversionStartN;

    // mode decode: the wire-count bit overrides the straps
    wire [1:0] sel = {syncB_q.interfaceSelectA, syncB_q.interfaceSelectB};
    assign modeD = twoWireEn ? ASP_MODE_TWO_WIRE :                     // see RULE3
                   (sel == `ASP_SEL_SPI)   ? ASP_MODE_SPI :
                   (sel == `ASP_SEL_EDGE)  ? ASP_MODE_EDGE :
                   (sel == `ASP_SEL_GATED) ? ASP_MODE_GATED : ASP_MODE_CONT; // see RULE23

    wire master   = (mode_q == ASP_MODE_GATED) | (mode_q == ASP_MODE_CONT);
    wire twoWire  = (mode_q == ASP_MODE_TWO_WIRE);
    wire edgeMode = (mode_q == ASP_MODE_EDGE);

    // bit timing comes from the pin clock as slave, the master clock as master
    wire bitRise = master ? mclkRise : sclkRise;
    wire bitFall = master ? mclkFall : sclkFall;
    wire rxBit   = twoWire ? syncB_q.dataIo : syncB_q.dataIn;

    // edge mode frames on the sync fall only; other slave modes run while sync is low
    wire slaveStart  = ~master & (edgeMode ? fsyncFall :
                       (~frameActive_q & ~syncB_q.frameSyncN));      // see RULE21
    wire slaveAbort  = ~master & ~edgeMode & syncB_q.frameSyncN;       // see RULE10
    wire masterStart = master & pend_q & mclkFall & busy_q & ~frameActive_q; // see RULE6
    wire frameStart  = slaveStart | masterStart;
    wire wordDone    = frameActive_q & bitRise & (bitCnt_q == LAST_BIT);
    wire [WORD_W-1:0] rxWord = {rx_q[WORD_W-2:0], rxBit};
    wire readFrame   = twoWire & readDir_q;
    // zero words are dropped; a full buffer refuses the word
    wire push = wordDone & ~readFrame & (|rxWord) & bufInReady;         // see RULE2
    wire startReq = (cstFall | swConvStart) & ~busy_q;                  // see RULE7

    // mode only changes between frames, so a frame never switches half way
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_q <= ASP_MODE_SPI;
        end else if (!frameActive_q) begin
            mode_q <= modeD;
        end
    end

    // frame sequencer and shift registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            frameActive_q <= 1'b0;
            readDir_q     <= 1'b0;
            bitCnt_q      <= '0;
            tx_q          <= '0;
            rx_q          <= '0;
        end else if (frameStart) begin
            frameActive_q <= 1'b1;
            readDir_q     <= pending_q;                                 // see RULE4
            bitCnt_q      <= '0;
            tx_q          <= result_q;                                  // see RULE16
        end else if (wordDone | slaveAbort) begin
            frameActive_q <= 1'b0;
            bitCnt_q      <= '0;
        end else if (frameActive_q) begin
            if (bitRise) begin
                bitCnt_q <= bitCnt_q + 1'b1;
                rx_q     <= rxWord;                                     // see RULE1
            end
            if (bitFall && bitCnt_q != '0) begin
                tx_q <= {tx_q[WORD_W-2:0], 1'b0};
            end
        end
    end

    // conversion state; a result arriving as the old one is read still counts
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_q      <= 1'b0;
            pending_q   <= 1'b0;
            pend_q      <= 1'b0;
            result_q    <= `ASP_RESULT_RST;
            convStart_q <= 1'b0;
            convDone_q  <= 1'b0;
        end else begin
            convStart_q <= startReq;
            convDone_q  <= convDoneIn;                                  // see RULE15
            if (convDoneIn) begin
                busy_q   <= 1'b0;
                result_q <= convResult;
            end else if (startReq) begin
                busy_q <= 1'b1;
            end
            if (convDoneIn) begin
                pending_q <= 1'b1;
            end else if (wordDone && (!twoWire || readDir_q)) begin
                pending_q <= 1'b0;
            end
            // master frames are armed by the start pin rising or a software start
            // a new arm landing with a frame start wins over the clear
            if (cstRise | swConvStart) begin
                pend_q <= master;
            end else if (masterStart) begin
                pend_q <= 1'b0;
            end
        end
    end

    // pin drivers, all registered so the pads never see decode glitches
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dataBit_q   <= 1'b0;
            dataOutOe_q <= 1'b0;
            dataIoOe_q  <= 1'b0;
            sclkOut_q   <= 1'b0;
            sclkOe_q    <= 1'b0;
            fsyncN_q    <= 1'b1;
            fsyncOe_q   <= 1'b0;
        end else begin
            dataBit_q   <= tx_q[WORD_W-1];
            dataOutOe_q <= frameActive_q & ~twoWire;
            dataIoOe_q  <= frameActive_q & readFrame;                   // see RULE4
            sclkOut_q   <= master & syncB_q.masterClockIn &
                           ((mode_q == ASP_MODE_CONT) | frameActive_q); // see RULE22
            sclkOe_q    <= master;
            fsyncN_q    <= ~(master & frameActive_q);
            fsyncOe_q   <= master;
        end
    end

    asp_buf #(
        .WIDTH (WORD_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .inValid  (push),
        .inData   (rxWord),
        .inReady  (bufInReady),
        .outValid (wrValid),
        .outData  (wrWord),
        .outReady (wrReady)
    );

    assign dataOut        = dataBit_q;
    assign dataIoOut      = dataBit_q;
    assign dataOutOe      = dataOutOe_q;
    assign dataIoOe       = dataIoOe_q;
    assign serialClockOut = sclkOut_q;
    assign serialClockOe  = sclkOe_q;
    assign frameSyncOutN  = fsyncN_q;
    assign frameSyncOe    = fsyncOe_q;
    assign busy           = busy_q;
    assign mode           = mode_q;
    assign convStart      = convStart_q;
    assign convDone       = convDone_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_zero_drop: assert property (wrValid |-> wrWord != '0) // see RULE2
        else $error("zero word was forwarded");
    chk_two_wire_gate: assert property (dataIoOe_q |-> $past(twoWire)) // see RULE3
        else $error("data pin driven outside two-wire mode");
    chk_one_dir: assert property ((wordDone && readFrame) |-> !push) // see RULE4
        else $error("read frame also wrote");
    chk_master_busy: assert property (masterStart |-> busy_q) // see RULE6
        else $error("master frame outside conversion");
    chk_edge_count: assert property (($fell(frameActive_q) && edgeMode)
        |-> $past(bitCnt_q) == LAST_BIT) // see RULE21
        else $error("edge frame ended early");
    chk_done_flag: assert property (convDoneIn |=> (convDone_q && !busy_q)) // see RULE15
        else $error("done not indicated");
    chk_conv_start: assert property ((cstFall && !busy_q) |=> (convStart_q && busy_q)) // see RULE7
        else $error("start pulse ignored");
    chk_gated_clock: assert property ((mode_q == ASP_MODE_GATED && !frameActive_q)
        |=> !sclkOut_q) // see RULE22
        else $error("gated clock ran outside frame");
    chk_duplex_load: assert property (frameStart |=> tx_q == $past(result_q)) // see RULE16
        else $error("result not loaded at frame start");
endmodule

/* dv/asp_host_model.sv */
`timescale 1ns/1ps
module asp_host_model (
    // frame request from the bench
    input  wire logic        go,
    input  wire logic        edgeSync,
    input  wire logic [15:0] txWord,
    input  wire logic        rxLine,
    output logic             done,
    output logic [15:0]      rxWord,
    // host pins towards the port
    output logic             serialClock,
    output logic             frameSyncN,
    output logic             dataIn
);
    // clock idles high and stands still between frames
    initial begin
        serialClock = 1'b1;
        frameSyncN  = 1'b1;
        dataIn      = 1'b1;
        done        = 1'b0;
        rxWord      = 16'h0000;
    end

    // one frame of sixteen clocks, odd phase so edges never meet sys_clk edges
    always @(posedge go) begin
        done = 1'b0;
        frameSyncN = 1'b0;
        #121.5;
        for (int i = 15; i >= 0; i--) begin
            serialClock = 1'b0;
            dataIn = txWord[i];
            #40;
            rxWord[i] = rxLine; // port bit is taken on the rising edge
            serialClock = 1'b1;
            #40;
        end
        #40;
        if (edgeSync) begin
            #400; // sync held past the count
        end
        frameSyncN = 1'b1;
        dataIn = ~dataIn; // released line shows no stale bit
        done = 1'b1;
    end
endmodule

/* dv/asp_port_tb.sv */
`timescale 1ns/1ps
module asp_port_tb;
    import asp_pkg::*;
    // bench-driven levels
    logic         sys_clk     = 1'b0;
    logic         rst_n       = 1'b0;
    logic         mclk        = 1'b0;
    logic         cnvN        = 1'b1;
    logic         selA        = 1'b0;
    logic         selB        = 1'b0;
    logic         twoWireEn   = 1'b0;
    logic         swConvStart = 1'b0;
    logic         wrReady     = 1'b0;
    logic         go          = 1'b0;
    logic         edgeSync    = 1'b0;
    logic         ioSeen      = 1'b0;
    logic         outSeen     = 1'b0;
    logic [15:0]  txWord      = 16'h0000;
    logic [15:0]  convResult  = 16'h3A5C;
    logic [7:0]   engCnt      = 8'h00;
    int           bad_count   = 0;
    int           check_count = 0;
    // design outputs and shared lines
    logic         dataOut, dataOutOe, dataIoOut, dataIoOe, serialClockOut, serialClockOe;
    logic         frameSyncOutN, frameSyncOe, busy, convStart, convDone, convDoneIn;
    logic         wrValid, done, sclk, fsyncN, hostData, ioLine, rxLine;
    logic [15:0]  wrWord, rxWord;
    asp_mode_type mode;
    asp_pins_type linePins;

    always #2 sys_clk = ~sys_clk;
    always #20 mclk = ~mclk; // free-running, never tied to the port clock

    // wire levels: the port wins the data pin only while it enables it
    assign ioLine = (dataIoOe === 1'b1) ? dataIoOut : hostData;
    assign rxLine = twoWireEn ? ioLine : dataOut;
    assign linePins = {sclk, fsyncN, hostData, ioLine, cnvN, mclk, selA, selB};
    wire logic [4:0] evt = {busy, convDone, wrValid, ~frameSyncOutN, done};

    // engine stand-in: result ready 200 cycles after each start
    always @(posedge sys_clk) begin
        if (convStart === 1'b1) begin
            engCnt <= 8'hC8;
        end else if (engCnt != 8'h00) begin
            engCnt <= engCnt - 8'h01;
        end
        if (dataIoOe === 1'b1) begin
            ioSeen <= 1'b1;
        end
        if (dataOutOe === 1'b1) begin
            outSeen <= 1'b1;
        end
    end
    assign convDoneIn = (engCnt == 8'h01);

    asp_port dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .linePins(linePins),
        .dataOut(dataOut), .dataOutOe(dataOutOe), .dataIoOut(dataIoOut), .dataIoOe(dataIoOe),
        .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
        .frameSyncOutN(frameSyncOutN), .frameSyncOe(frameSyncOe), .busy(busy),
        .twoWireEn(twoWireEn), .swConvStart(swConvStart), .mode(mode),
        .convStart(convStart), .convDoneIn(convDoneIn), .convResult(convResult),
        .convDone(convDone), .wrValid(wrValid), .wrWord(wrWord), .wrReady(wrReady)
    );

    asp_host_model host (
        .go(go), .edgeSync(edgeSync), .txWord(txWord), .rxLine(rxLine), .done(done),
        .rxWord(rxWord), .serialClock(sclk), .frameSyncN(fsyncN), .dataIn(hostData)
    );

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // bounded wait on one event line; running out ends the run
    task automatic waitEvt(input int k, input int lim);
        int n;
        n = 0;
        while (evt[k] !== 1'b1 && n < lim) begin
            tick();
            n++;
        end
        chk(16'(n < lim), 16'h0001);
        if (n >= lim) begin
            tally_and_finish();
        end
    endtask

    task automatic frame(input logic [15:0] tx, input logic es);
        txWord = tx;
        edgeSync = es;
        go = 1'b1;
        tick();
        go = 1'b0;
        tick();
        waitEvt(0, 1000);
        repeat (10) tick(); // let the port see sync high again
    endtask

    task automatic drain();
        wrReady = 1'b1;
        tick();
        wrReady = 1'b0;
        tick();
    endtask

    task automatic swStart();
        swConvStart = 1'b1;
        tick();
        swConvStart = 1'b0;
        waitEvt(3, 300);
    endtask

    initial begin
        repeat (8) tick();
        rst_n = 1'b1;
        repeat (4) tick();
        chk(16'(mode), 16'(ASP_MODE_SPI));
        chk(16'(frameSyncOutN), 16'h0001);
        swStart();
        frame(16'hC3A1, 1'b0);
        chk(rxWord, 16'h3A5C);
        chk(16'(outSeen), 16'h0001);
        waitEvt(2, 8);
        chk(wrWord, 16'hC3A1);
        drain();
        // read-only use: pin start, all-zero word in
        convResult = 16'h1234;
        cnvN = 1'b0;
        repeat (3) tick();
        cnvN = 1'b1;
        waitEvt(3, 300);
        frame(16'h0000, 1'b0);
        chk(rxWord, 16'h1234);
        chk(16'(wrValid), 16'h0000);
        // edge framing with a stalled reader: third word finds the buffer full
        selB = 1'b1;
        repeat (6) tick();
        chk(16'(mode), 16'(ASP_MODE_EDGE));
        for (int w = 1; w <= 3; w++) begin
            frame(16'(w) * 16'h0101, 1'b1);
        end
        for (int w = 1; w <= 2; w++) begin
            chk(16'(wrValid), 16'h0001);
            chk(wrWord, 16'(w) * 16'h0101);
            drain();
        end
        chk(16'(wrValid), 16'h0000);
        // two-wire: write with nothing pending, then read after a conversion
        selB = 1'b0;
        twoWireEn = 1'b1;
        repeat (6) tick();
        chk(16'(mode), 16'(ASP_MODE_TWO_WIRE));
        ioSeen = 1'b0;
        outSeen = 1'b0;
        frame(16'h0A0F, 1'b0);
        chk(16'(ioSeen), 16'h0000);
        chk(wrWord, 16'h0A0F);
        drain();
        convResult = 16'h2B6D;
        swStart();
        frame(16'h0000, 1'b0);
        chk(rxWord, 16'h2B6D);
        chk(16'(ioSeen), 16'h0001);
        chk(16'(outSeen), 16'h0000);
        chk(16'(wrValid), 16'h0000);
        // self-clocking: pin start only, frame while busy
        twoWireEn = 1'b0;
        selA = 1'b1; // port makes clock and sync from the master clock; the bench checks their enables, waits for sync low and checks the gated clock is low
        selB = 1'b1;
        repeat (6) tick();
        chk(16'(mode), 16'(ASP_MODE_CONT));
        chk(16'(serialClockOe), 16'h0001);
        cnvN = 1'b0;
        repeat (3) tick();
        cnvN = 1'b1;
        waitEvt(1, 100);
        chk(16'(busy), 16'h0001);
        chk(16'(frameSyncOe), 16'h0001);
        waitEvt(3, 300);
        selB = 1'b0;
        repeat (30) tick();
        chk(16'(mode), 16'(ASP_MODE_GATED));
        chk(16'(serialClockOut), 16'h0000);
        tally_and_finish();
    end
endmodule
